// ===== src/spee_defines.svh
// Constants for the serial EEPROM slave: opcodes, status layout, protection codes and timing
`ifndef SPEE_DEFINES_SVH
`define SPEE_DEFINES_SVH

// ==========================================================================
// Opcodes
`define SPEE_OP_LATCH_ON 8'h06
`define SPEE_OP_LATCH_OFF 8'h04
`define SPEE_OP_STAT_RD 8'h05
`define SPEE_OP_STAT_WR 8'h01
`define SPEE_OP_RD_LO 3'h3
`define SPEE_OP_WR_LO 3'h2
`define SPEE_OP_TOP_BIT 3

// ==========================================================================
// Status byte layout
`define SPEE_ST_BUSY 0
`define SPEE_ST_LATCH 1
`define SPEE_ST_BP_LO 2
`define SPEE_ST_BP_HI 3

// ==========================================================================
// Array geometry and protection codes
`define SPEE_ADDR_W 9
`define SPEE_MEM_DEPTH 512
`define SPEE_PAGE_BYTES 16
`define SPEE_BP_NONE 2'h0
`define SPEE_BP_QUARTER 2'h1
`define SPEE_BP_HALF 2'h2
`define SPEE_BP_ALL 2'h3
`define SPEE_BP_RESET 2'h0

// ==========================================================================
// Timing
`define SPEE_TWC_MS 5
`define SPEE_SYS_KHZ 125000
`define SPEE_TWC_CYCLES 20'(`SPEE_TWC_MS * `SPEE_SYS_KHZ)

`endif

// ===== src/spee_pkg.sv
// Types shared by the serial EEPROM slave
package spee_pkg;

    // ==========================================================================
    // Link-side sequence phase
    typedef enum logic [2:0] {
        PH_CMD,
        PH_ADDR,
        PH_WDATA,
        PH_SDATA,
        PH_RD,
        PH_STAT,
        PH_DONE,
        PH_IGNORE
    } spee_phase_e;

    // ==========================================================================
    // What a rising chip select would commit
    typedef enum logic [2:0] {
        END_NONE,
        END_LATCH_ON,
        END_LATCH_OFF,
        END_WRITE,
        END_STATUS
    } spee_end_e;

endpackage

// ===== src/spee_top.sv
// Serial EEPROM slave: link logic on the serial clock, array and write cycle on sys_clk
`timescale 1ns/1ps
`include "spee_defines.svh"

module spee_top #(
    parameter logic [19:0] WRITE_CYCLES = `SPEE_TWC_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic so,
    output logic so_oe_n,
    output logic write_in_progress,
    output logic enable_latch,
    output logic block_protect_lo,
    output logic block_protect_hi
);

    // ==========================================================================
    // Declarations
    logic rst_link_q;
    logic cs_rst;
    logic in_frame_q;
    logic fresh;
    spee_pkg::spee_phase_e phase_q;
    spee_pkg::spee_phase_e ph_eff;
    logic [2:0] bitcnt_q;
    logic [2:0] bit_eff;
    logic [7:0] sr_q;
    logic [7:0] byte_in;
    logic [8:0] addr_q;
    logic is_read_q;
    logic [7:0] stat_data_q;
    spee_pkg::spee_end_e end_kind_q;
    logic tgl_q;
    logic [7:0] buf_q [`SPEE_PAGE_BYTES];
    logic [15:0] mask_q;
    logic busy_k1_q, busy_k2_q;
    logic latch_k1_q, latch_k2_q;
    logic [1:0] bp_k1_q, bp_k2_q;
    logic [7:0] status_k;
    logic [7:0] out_byte;
    logic drive_q;
    logic so_q;
    logic [7:0] mem_q [`SPEE_MEM_DEPTH];
    logic cs_s1_q, cs_s2_q, cs_s3_q;
    logic wp_s1_q, wp_s2_q;
    logic tgl_s1_q, tgl_s2_q;
    spee_pkg::spee_end_e end_s1_q, end_s2_q;
    logic cs_seen_q;
    logic last_tgl_q;
    logic cs_rise;
    logic commit;
    logic protected_pg;
    logic start_wr;
    logic start_st;
    logic busy_q;
    logic latch_q;
    logic [1:0] bp_q;
    logic [19:0] timer_q;
    logic wr_kind_q;
    logic [4:0] page_q;
    logic [15:0] copy_mask_q;
    logic [1:0] stat_hold_q;
    logic done;

    // ==========================================================================
    // Link reset: sys reset held into the serial clock logic, frame reset from select
    always_ff @(posedge sys_clk) begin
        rst_link_q <= rst;
    end

    assign cs_rst = cs_n | rst_link_q;

    // First rising edge of a frame is only possible once select is low
    always_ff @(posedge sck or posedge cs_rst) begin
        if (cs_rst) begin
            in_frame_q <= 1'b0;
        end else if (hold_n) begin
            in_frame_q <= 1'b1;
        end
    end

    assign fresh = ~in_frame_q;

    always_comb begin
        bit_eff = fresh ? 3'h0 : bitcnt_q;
        ph_eff = fresh ? spee_pkg::PH_CMD : phase_q;
        byte_in = {sr_q[6:0], si};
    end

    // ==========================================================================
    // Status levels brought into the serial clock domain
    always_ff @(posedge sck or posedge rst_link_q) begin
        if (rst_link_q) begin
            busy_k1_q <= 1'b0;
            busy_k2_q <= 1'b0;
            latch_k1_q <= 1'b0;
            latch_k2_q <= 1'b0;
            bp_k1_q <= `SPEE_BP_RESET;
            bp_k2_q <= `SPEE_BP_RESET;
        end else begin
            busy_k1_q <= busy_q;
            busy_k2_q <= busy_k1_q;
            latch_k1_q <= latch_q;
            latch_k2_q <= latch_k1_q;
            bp_k1_q <= bp_q;
            bp_k2_q <= bp_k1_q;
        end
    end

    always_comb begin
        status_k = 8'h00;
        status_k[`SPEE_ST_BUSY] = busy_k2_q;
        status_k[`SPEE_ST_LATCH] = latch_k2_q;
        status_k[`SPEE_ST_BP_LO] = bp_k2_q[0];
        status_k[`SPEE_ST_BP_HI] = bp_k2_q[1];
    end

    // ==========================================================================
    // Sequence decode on rising serial clock; frozen while paused
    always_ff @(posedge sck or posedge rst_link_q) begin
        if (rst_link_q) begin
            phase_q <= spee_pkg::PH_IGNORE;
            bitcnt_q <= 3'h0;
            sr_q <= 8'h00;
            addr_q <= 9'h000;
            is_read_q <= 1'b0;
            stat_data_q <= 8'h00;
            end_kind_q <= spee_pkg::END_NONE;
            tgl_q <= 1'b0;
        end else if (hold_n) begin
            sr_q <= byte_in;
            bitcnt_q <= bit_eff + 3'h1;
            phase_q <= ph_eff;
            end_kind_q <= spee_pkg::END_NONE;
            if (fresh) begin
                tgl_q <= ~tgl_q;
            end
            unique case (ph_eff)
                spee_pkg::PH_CMD: begin
                    if (bit_eff == 3'h7) begin
                        if (byte_in[7:4] == 4'h0 && byte_in[2:0] == `SPEE_OP_RD_LO) begin
                            addr_q[8] <= byte_in[`SPEE_OP_TOP_BIT];
                            is_read_q <= 1'b1;
                            phase_q <= spee_pkg::PH_ADDR;
                        end else if (byte_in[7:4] == 4'h0 && byte_in[2:0] == `SPEE_OP_WR_LO) begin
                            addr_q[8] <= byte_in[`SPEE_OP_TOP_BIT];
                            is_read_q <= 1'b0;
                            phase_q <= spee_pkg::PH_ADDR;
                        end else if (byte_in == `SPEE_OP_LATCH_ON) begin
                            end_kind_q <= spee_pkg::END_LATCH_ON;
                            phase_q <= spee_pkg::PH_DONE;
                        end else if (byte_in == `SPEE_OP_LATCH_OFF) begin
                            end_kind_q <= spee_pkg::END_LATCH_OFF;
                            phase_q <= spee_pkg::PH_DONE;
                        end else if (byte_in == `SPEE_OP_STAT_RD) begin
                            phase_q <= spee_pkg::PH_STAT;
                        end else if (byte_in == `SPEE_OP_STAT_WR) begin
                            phase_q <= spee_pkg::PH_SDATA;
                        end else begin
                            phase_q <= spee_pkg::PH_IGNORE;
                        end
                    end
                end
                spee_pkg::PH_ADDR: begin
                    if (bit_eff == 3'h7) begin
                        addr_q[7:0] <= byte_in;
                        if (!is_read_q) begin
                            phase_q <= spee_pkg::PH_WDATA;
                        end else if (busy_k2_q) begin
                            phase_q <= spee_pkg::PH_IGNORE;
                        end else begin
                            phase_q <= spee_pkg::PH_RD;
                        end
                    end
                end
                spee_pkg::PH_WDATA: begin
                    if (bit_eff == 3'h7) begin
                        addr_q[3:0] <= addr_q[3:0] + 4'h1;
                        end_kind_q <= spee_pkg::END_WRITE;
                    end
                end
                spee_pkg::PH_SDATA: begin
                    if (bit_eff == 3'h7) begin
                        stat_data_q <= byte_in;
                        end_kind_q <= spee_pkg::END_STATUS;
                        phase_q <= spee_pkg::PH_DONE;
                    end
                end
                spee_pkg::PH_RD: begin
                    if (bit_eff == 3'h7) begin
                        addr_q <= addr_q + 9'h001;
                    end
                end
                spee_pkg::PH_STAT, spee_pkg::PH_DONE, spee_pkg::PH_IGNORE: begin
                end
            endcase
        end
    end

    // ==========================================================================
    // Page buffer: bytes land at the in-page address, later ones overwrite
    always_ff @(posedge sck) begin
        if (hold_n && ph_eff == spee_pkg::PH_WDATA && bit_eff == 3'h7) begin
            buf_q[addr_q[3:0]] <= byte_in;
        end
    end

    always_ff @(posedge sck or posedge rst_link_q) begin
        if (rst_link_q) begin
            mask_q <= 16'h0000;
        end else if (hold_n) begin
            if (fresh) begin
                mask_q <= 16'h0000;
            end else if (phase_q == spee_pkg::PH_WDATA && bitcnt_q == 3'h7) begin
                mask_q[addr_q[3:0]] <= 1'b1;
            end
        end
    end

    // ==========================================================================
    // Serial output, changed after falling edges
    assign out_byte = (phase_q == spee_pkg::PH_RD) ? mem_q[addr_q] : status_k;

    always_ff @(negedge sck or posedge cs_rst) begin
        if (cs_rst) begin
            drive_q <= 1'b0;
            so_q <= 1'b0;
        end else if (hold_n) begin
            drive_q <= in_frame_q && (phase_q == spee_pkg::PH_RD || phase_q == spee_pkg::PH_STAT);
            so_q <= out_byte[~bitcnt_q];
        end
    end

    assign so = so_q;
    assign so_oe_n = ~(drive_q & ~cs_n & hold_n);

    // ==========================================================================
    // Pin and link synchronisers on sys_clk
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            wp_s1_q <= 1'b0;
            wp_s2_q <= 1'b0;
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            end_s1_q <= spee_pkg::END_NONE;
            end_s2_q <= spee_pkg::END_NONE;
        end else begin
            cs_s1_q <= cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            wp_s1_q <= wp_n;
            wp_s2_q <= wp_s1_q;
            tgl_s1_q <= tgl_q;
            tgl_s2_q <= tgl_s1_q;
            end_s1_q <= end_kind_q;
            end_s2_q <= end_s1_q;
        end
    end

    // ==========================================================================
    // Frame commit on rising select
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cs_seen_q <= 1'b0;
            last_tgl_q <= 1'b0;
        end else begin
            if (!cs_s2_q) begin
                cs_seen_q <= 1'b1;
            end
            if (cs_rise) begin
                last_tgl_q <= tgl_s2_q;
            end
        end
    end

    assign cs_rise = cs_s2_q & ~cs_s3_q;
    assign commit = cs_rise & cs_seen_q & (tgl_s2_q != last_tgl_q);

    always_comb begin
        unique case (bp_q)
            `SPEE_BP_NONE: protected_pg = 1'b0;
            `SPEE_BP_QUARTER: protected_pg = addr_q[8] & addr_q[7];
            `SPEE_BP_HALF: protected_pg = addr_q[8];
            `SPEE_BP_ALL: protected_pg = 1'b1;
        endcase
    end

    assign start_wr = commit && end_s2_q == spee_pkg::END_WRITE && latch_q && wp_s2_q && !busy_q && !protected_pg;
    assign start_st = commit && end_s2_q == spee_pkg::END_STATUS && latch_q && wp_s2_q && !busy_q;

    // ==========================================================================
    // Self-timed write cycle
    assign done = busy_q && timer_q == WRITE_CYCLES - 20'h00001;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busy_q <= 1'b0;
            timer_q <= 20'h00000;
            wr_kind_q <= 1'b0;
            page_q <= 5'h00;
            copy_mask_q <= 16'h0000;
            stat_hold_q <= `SPEE_BP_RESET;
        end else if (start_wr || start_st) begin
            busy_q <= 1'b1;
            timer_q <= 20'h00000;
            wr_kind_q <= start_wr;
            page_q <= addr_q[8:4];
            copy_mask_q <= mask_q;
            stat_hold_q <= stat_data_q[`SPEE_ST_BP_HI:`SPEE_ST_BP_LO];
        end else if (busy_q) begin
            timer_q <= timer_q + 20'h00001;
            if (done) begin
                busy_q <= 1'b0;
            end
        end
    end

    // Array programming during the first cycles of a data write
    always_ff @(posedge sys_clk) begin
        if (busy_q && wr_kind_q && timer_q < 20'h00010 && copy_mask_q[timer_q[3:0]]) begin
            mem_q[{page_q, timer_q[3:0]}] <= buf_q[timer_q[3:0]];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bp_q <= `SPEE_BP_RESET;
        end else if (done && !wr_kind_q) begin
            bp_q <= stat_hold_q;
        end
    end

    // ==========================================================================
    // Enable latch
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            latch_q <= 1'b0;
        end else if (!wp_s2_q) begin
            latch_q <= 1'b0;
        end else if (done) begin
            latch_q <= 1'b0;
        end else if (commit && end_s2_q == spee_pkg::END_LATCH_ON) begin
            latch_q <= 1'b1;
        end else if (commit && end_s2_q == spee_pkg::END_LATCH_OFF) begin
            latch_q <= 1'b0;
        end
    end

    assign write_in_progress = busy_q;
    assign enable_latch = latch_q;
    assign block_protect_lo = bp_q[0];
    assign block_protect_hi = bp_q[1];

    // ==========================================================================
    // Assertions
    logic [20:0] busy_len_q;

    always_ff @(posedge sys_clk) begin
        if (rst || !busy_q) begin
            busy_len_q <= 21'h000000;
        end else begin
            busy_len_q <= busy_len_q + 21'h000001;
        end
    end

    sequence s_valid_write_end;
        commit && end_s2_q == spee_pkg::END_WRITE && latch_q && wp_s2_q && !busy_q && !protected_pg;
    endsequence

    a_float_deselect: assert property (@(posedge sys_clk) disable iff (rst) cs_n |-> so_oe_n)
        else $error("serial output driven while deselected");
    a_float_pause: assert property (@(posedge sys_clk) disable iff (rst) !hold_n |-> so_oe_n)
        else $error("serial output driven while paused");
    a_write_start: assert property (@(posedge sys_clk) disable iff (rst) s_valid_write_end |=> busy_q && timer_q == 20'h00000)
        else $error("valid write sequence did not start a cycle");
    a_cycle_holds: assert property (@(posedge sys_clk) disable iff (rst) $rose(busy_q) |-> busy_q [*8])
        else $error("write cycle cut short");
    a_wp_no_abort: assert property (@(posedge sys_clk) disable iff (rst) (busy_q && !done && !wp_s2_q) |=> busy_q)
        else $error("protect pin aborted a write cycle");
    a_wp_clears: assert property (@(posedge sys_clk) disable iff (rst) !wp_s2_q |=> !latch_q)
        else $error("enable latch set while protect pin low");
    a_end_clears: assert property (@(posedge sys_clk) disable iff (rst) $fell(busy_q) |-> !latch_q)
        else $error("enable latch still set after write cycle");
    a_cycle_bound: assert property (@(posedge sys_clk) disable iff (rst) busy_len_q <= {1'b0, WRITE_CYCLES})
        else $error("write cycle overran its time");
    a_no_early_cmd: assert property (@(posedge sys_clk) disable iff (rst) !cs_seen_q |=> !busy_q && !$rose(latch_q))
        else $error("command accepted before select seen low");
    a_protect_block: assert property (@(posedge sys_clk) disable iff (rst)
        (commit && !busy_q && (!latch_q || protected_pg) && end_s2_q == spee_pkg::END_WRITE) |=> !busy_q)
        else $error("protected or unlatched write started a cycle");

endmodule

// ===== verification/spee_host.sv
// SPI host model that drives the serial link of the EEPROM slave
`timescale 1ns/1ps
module spee_host (
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    input wire logic so,
    input wire logic so_oe_n
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
    end
    // ==========================================================================
    // Frame edges; select stays high long enough for the commit
    task automatic start();
        cs_n = 1'b0;
        #30;
    endtask
    task automatic stop();
        #15;
        cs_n = 1'b1;
        si = ~si;
        #210;
    endtask
    // ==========================================================================
    // Shifts n bits MSB first; a floating output reads as unknown
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            si = tx[i];
            #15 sck = 1'b1;
            rx[i] = so_oe_n ? 1'bx : so;
            #15 sck = 1'b0;
        end
    endtask
    // ==========================================================================
    // Pause with clock low, toggle junk, release with clock low
    task automatic pause(output logic oe_seen);
        hold_n = 1'b0;
        #1 oe_seen = so_oe_n;
        repeat (2) begin
            si = ~si;
            #14 sck = 1'b1;
            #15 sck = 1'b0;
        end
        #15 hold_n = 1'b1;
        #15;
    endtask
endmodule

// ===== verification/tb_spee_top.sv
// Self-checking testbench of the serial EEPROM slave
`timescale 1ns/1ps
module tb_spee_top;
    logic sys_clk, rst, wp_n, sck, cs_n, si, hold_n;
    logic so, so_oe_n, busy, latch, bp_lo, bp_hi, oe_seen;
    logic [7:0] rx;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;

    spee_top #(.WRITE_CYCLES(20'h00190)) DUT (.sys_clk(sys_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n), .write_in_progress(busy),
        .enable_latch(latch), .block_protect_lo(bp_lo), .block_protect_hi(bp_hi));
    spee_host host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe_n(so_oe_n));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    // ==========================================================================
    // Compare and closing tasks
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_bit(input string nm, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %b, seen %b", nm, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==========================================================================
    // Frame helpers
    task automatic op1(input logic [7:0] op);
        host.start();
        host.xfer(op, 8, rx);
        host.stop();
    endtask
    task automatic op2(input logic [7:0] op, input logic [7:0] b);
        host.start();
        host.xfer(op, 8, rx);
        host.xfer(b, 8, rx);
        host.stop();
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d[$]);
        op1(8'h06);
        host.start();
        host.xfer({4'h0, a[8], 3'h2}, 8, rx);
        host.xfer(a[7:0], 8, rx);
        foreach (d[i]) host.xfer(d[i], 8, rx);
        host.stop();
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] e[$]);
        host.start();
        host.xfer({4'h0, a[8], 3'h3}, 8, rx);
        host.xfer(a[7:0], 8, rx);
        foreach (e[i]) begin
            host.xfer(8'h00, 8, rx);
            chk("read byte", e[i], rx);
        end
        host.stop();
        chk_bit("so_oe_n", 1'b1, so_oe_n);
    endtask
    task automatic status_read_cmd(input logic [7:0] e);
        op2(8'h05, 8'h00);
        chk("status", e, rx);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge sys_clk);
        repeat (2) @(negedge sys_clk);
        chk_bit("write_in_progress", 1'b0, busy);
    endtask
    // ==========================================================================
    // Scenarios
    task automatic t_reset();
        chk_bit("so_oe_n", 1'b1, so_oe_n);
        chk("flags", 8'h00, {4'h0, bp_hi, bp_lo, latch, busy});
    endtask
    task automatic t_latch();
        op1(8'h06);
        chk_bit("enable_latch", 1'b1, latch);
        status_read_cmd(8'h02);
        op1(8'h04);
        chk_bit("enable_latch", 1'b0, latch);
        op2(8'h06, 8'h00);
        chk_bit("enable_latch", 1'b0, latch);
    endtask
    task automatic t_page();
        logic [7:0] q[$];
        for (int i = 0; i < 17; i++) q.push_back(8'h40 + 8'(i));
        wr(9'h1fe, q);
        chk_bit("write_in_progress", 1'b1, busy);
        status_read_cmd(8'h03);
        rd(9'h1fe, {8'hxx});
        wait_idle();
        chk_bit("enable_latch", 1'b0, latch);
    endtask
    task automatic t_wp_during();
        wr(9'h000, {8'h3c});
        @(negedge sys_clk) wp_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk_bit("write_in_progress", 1'b1, busy);
        wait_idle();
        wp_n = 1'b1;
        rd(9'h1fc, {8'h4e, 8'h4f, 8'h50, 8'h41, 8'h3c});
    endtask
    task automatic t_wp();
        op1(8'h06);
        @(negedge sys_clk) wp_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk_bit("enable_latch", 1'b0, latch);
        wr(9'h020, {8'h11});
        chk_bit("write_in_progress", 1'b0, busy);
        status_read_cmd(8'h00);
        @(negedge sys_clk) wp_n = 1'b1;
    endtask
    task automatic t_abort();
        op1(8'h06);
        host.start();
        host.xfer(8'h02, 8, rx);
        host.xfer(8'h30, 8, rx);
        host.xfer(8'h77, 4, rx);
        host.stop();
        chk_bit("write_in_progress", 1'b0, busy);
        op1(8'h04);
    endtask
    task automatic t_protect();
        op1(8'h06);
        op2(8'h01, 8'h0c);
        wait_idle();
        chk("protect", 8'h03, {6'h00, bp_hi, bp_lo});
        chk_bit("enable_latch", 1'b0, latch);
        wr(9'h000, {8'h99});
        chk_bit("write_in_progress", 1'b0, busy);
        op1(8'h06);
        op2(8'h01, 8'h04);
        wait_idle();
        chk("protect", 8'h01, {6'h00, bp_hi, bp_lo});
        wr(9'h180, {8'h99});
        chk_bit("write_in_progress", 1'b0, busy);
        wr(9'h100, {8'h5a});
        chk_bit("write_in_progress", 1'b1, busy);
        wait_idle();
        op1(8'h06);
        op2(8'h01, 8'h08);
        wait_idle();
        chk("protect", 8'h02, {6'h00, bp_hi, bp_lo});
        wr(9'h100, {8'h99});
        chk_bit("write_in_progress", 1'b0, busy);
        op1(8'h06);
        op2(8'h01, 8'h00);
        wait_idle();
        chk("protect", 8'h00, {6'h00, bp_hi, bp_lo});
        rd(9'h100, {8'h5a});
    endtask
    task automatic t_pause();
        host.start();
        host.xfer(8'h0b, 8, rx);
        host.xfer(8'hff, 4, rx);
        host.pause(oe_seen);
        chk_bit("so_oe_n", 1'b1, oe_seen);
        host.xfer(8'hf0, 4, rx);
        host.xfer(8'h00, 8, rx);
        chk("read byte", 8'h41, rx);
        host.stop();
    endtask
    task automatic t_unknown();
        op2(8'hff, 8'h00);
        chk("unknown op output", 8'hxx, rx);
        rd(9'h1ff, {8'h41, 8'h3c});
    endtask
    // ==========================================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        wp_n = 1'b1;
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        t_reset();
        t_latch();
        t_page();
        t_wp_during();
        t_wp();
        t_abort();
        t_protect();
        t_pause();
        t_unknown();
        report_and_stop();
    end
endmodule
